/* inc/dim_pkg.sv */
// dim_pkg: register map, source bit layout and reset values of the
// two-level interrupt mask unit.
// assumes a 32-bit classic Wishbone slave on a single 100 MHz clock.
package dim_pkg;

    localparam int          DATA_W          = 32;
    localparam int          SEL_W           = 4;
    localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;

    // documented register byte addresses
    localparam logic [31:0] OFS_NORMAL_STATUS = 32'hFFFF_0000;
    localparam logic [31:0] OFS_NORMAL_RAW    = 32'hFFFF_0004;
    localparam logic [31:0] OFS_NORMAL_EN     = 32'hFFFF_0008;
    localparam logic [31:0] OFS_NORMAL_CLR    = 32'hFFFF_000C;
    localparam logic [31:0] OFS_FAST_STATUS   = 32'hFFFF_0100;
    localparam logic [31:0] OFS_FAST_RAW      = 32'hFFFF_0104;
    localparam logic [31:0] OFS_FAST_EN       = 32'hFFFF_0108;
    localparam logic [31:0] OFS_FAST_CLR      = 32'hFFFF_010C;
    // additional control and event registers
    localparam logic [31:0] OFS_SOFT_CFG      = 32'hFFFF_0200;
    localparam logic [31:0] OFS_CTRL_CFG      = 32'hFFFF_0204;
    localparam logic [31:0] OFS_EVENT_STATUS  = 32'hFFFF_0208;
    localparam logic [31:0] OFS_EVENT_MASK    = 32'hFFFF_020C;

    // source bit positions, identical in every level register
    localparam int BIT_FAST_OR    = 0;
    localparam int BIT_SOFT       = 1;
    localparam int BIT_TIMER0     = 2;
    localparam int BIT_SUPPLY_MON = 8;
    localparam int BIT_FLASH0     = 10;
    localparam int BIT_CONVERTER  = 12;
    localparam int BIT_UART       = 13;
    localparam int BIT_SPI        = 14;
    localparam int BIT_I2C0_MST   = 15;
    localparam int BIT_EXT0       = 19;
    localparam int BIT_PWM_TRIP   = 23;
    localparam int BIT_EXT4       = 24;
    localparam int BIT_LOGIC_REQ0 = 26;
    localparam int BIT_LOGIC_REQ1 = 27;

    // bits 1..6, 8, 10..27 exist; 0 is the fast OR, 7, 9, 28..31 read zero
    localparam logic [31:0] SRC_VALID    = 32'h0FFF_FD7E;
    // peripheral lines only: the software source is excluded
    localparam logic [31:0] PERIPH_VALID = 32'h0FFF_FD7C;

    // soft interrupt configuration and controller configuration fields
    localparam int          SOFT_NORMAL_BIT = 1;
    localparam int          SOFT_FAST_BIT   = 2;
    localparam logic [31:0] SOFT_CFG_VALID  = 32'h0000_0006;
    localparam int          NEST_NORMAL_BIT = 0;
    localparam int          NEST_FAST_BIT   = 1;
    localparam logic [31:0] CTRL_CFG_VALID  = 32'h0000_0003;

    // event status bits
    localparam int          EV_W          = 3;
    localparam int          EV_NORMAL     = 0;
    localparam int          EV_FAST       = 1;
    localparam int          EV_BAD_ADDR   = 2;
    localparam logic [2:0]  EV_RESET      = 3'h0;

    // sync stage count for the peripheral request lines
    localparam int          SYNC_STAGES   = 2;

endpackage

/* hdl/dim_sync.sv */
// dim_sync: two flip-flop synchroniser for the peripheral request lines.
// assumes the lines may come from other clock domains or pins.
`timescale 1ns/1ps
module dim_sync (
    input  wire logic                       REF_CLK,
    input  wire logic                       RST,
    input  wire logic [dim_pkg::DATA_W-1:0] ASYNC_IN,
    output logic      [dim_pkg::DATA_W-1:0] SYNC_OUT
);
    import dim_pkg::*;

    logic [DATA_W-1:0] stage1;

    // first stage is read only by the second, never by logic
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            stage1   <= RESET_VALUE;
            SYNC_OUT <= RESET_VALUE;
        end else begin
            stage1   <= ASYNC_IN;
            SYNC_OUT <= stage1;
        end
    end

endmodule // dim_sync

/* hdl/dim_top.sv */
// dim_top: two-level interrupt aggregation and masking unit with
// a classic Wishbone register slave and an event interrupt output.
// assumes request lines are levels held until the peripheral clears them.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// Function
// - accept 25 sources, one software, each separately maskable
// - same bit per source everywhere; 1 soft, 2-6 timers, 8 supply monitor
// - bits 10-27: flash, converter, UART, SPI, I2C, external, PWM, logic array
// - normal request line is OR of all normal masked status bits
// - normal raw register read-only, follows peripheral request lines
// - normal enable: write 1 sets, write 0 keeps, read returns mask
// - normal clear register write-only, 1 clears matching enable bit
// - normal status read-only, equals raw AND enable
// - no priority encoder, no vector; software picks the source
// - fast raw register read-only, follows peripheral request lines
// - fast enable: write 1 sets, write 0 keeps, read returns mask
// - fast clear register write-only, 1 clears matching fast enable bit
// - fast status read-only, equals fast raw AND fast enable
// - OR of fast status 31..1 drives fast line and bit 0 everywhere
// - enabling at one level clears same bit at the other level
// - nesting enable bits held in controller configuration, off by default
// - soft config bit 1 drives normal bit 1, bit 2 drives fast bit 1
module dim_top (
    input  wire logic                       REF_CLK,
    input  wire logic                       RST,
    input  wire logic                       WB_CYC_I,
    input  wire logic                       WB_STB_I,
    input  wire logic                       WB_WE_I,
    input  wire logic [dim_pkg::DATA_W-1:0] WB_ADR_I,
    input  wire logic [dim_pkg::SEL_W-1:0]  WB_SEL_I,
    input  wire logic [dim_pkg::DATA_W-1:0] WB_DAT_I,
    output logic      [dim_pkg::DATA_W-1:0] WB_DAT_O,
    output logic                            WB_ACK_O,
    input  wire logic [dim_pkg::DATA_W-1:0] PERIPH_REQ,
    output logic                            IRQ_OUT,
    output logic                            FIQ_OUT,
    output logic                            INT_OUT
);
    import dim_pkg::*;

    logic [DATA_W-1:0] periph_sync;
    logic [DATA_W-1:0] normal_en;
    logic [DATA_W-1:0] fast_en;
    logic [DATA_W-1:0] soft_cfg;
    logic [DATA_W-1:0] ctrl_cfg;
    logic [EV_W-1:0]   ev_status;
    logic [EV_W-1:0]   ev_mask;
    logic [DATA_W-1:0] normal_raw;
    logic [DATA_W-1:0] fast_raw;
    logic [DATA_W-1:0] normal_status;
    logic [DATA_W-1:0] fast_status;
    logic              fast_or;
    logic              irq_prev;
    logic              fiq_prev;
    logic              bus_req;
    logic              wr_strobe;
    logic              rd_strobe;
    logic [DATA_W-1:0] wdata;
    logic              addr_known;
    logic [DATA_W-1:0] next_rdata;

    // expand byte enables into a bit mask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = RESET_VALUE;
        for (int i = 0; i < SEL_W; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // put the fast OR into bit 0 and zero every unused position
    function automatic logic [DATA_W-1:0] shape(input logic [DATA_W-1:0] v,
                                                input logic              f_or);
        logic [DATA_W-1:0] r;
        r = v & SRC_VALID;
        r[BIT_FAST_OR] = f_or;
        return r;
    endfunction

    // request lines may come from other domains, so they are synchronised
    dim_sync u_sync (
        .REF_CLK  (REF_CLK),
        .RST      (RST),
        .ASYNC_IN (PERIPH_REQ),
        .SYNC_OUT (periph_sync)
    );

    // bus decode: one request cycle, answered one cycle later
    assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_strobe = bus_req & WB_WE_I;
    assign rd_strobe = bus_req & ~WB_WE_I;
    assign wdata     = WB_DAT_I & lane_mask(WB_SEL_I);

    // raw levels: peripheral lines plus the software source on bit 1
    always_comb begin
        normal_raw = periph_sync & PERIPH_VALID;
        fast_raw   = periph_sync & PERIPH_VALID;
        normal_raw[BIT_SOFT] = soft_cfg[SOFT_NORMAL_BIT];
        fast_raw[BIT_SOFT]   = soft_cfg[SOFT_FAST_BIT];
    end

    // masked status; no encoder or vector, software scans the bits
    assign normal_status = normal_raw & normal_en;
    assign fast_status   = fast_raw & fast_en;
    // bit 0 is excluded so the OR never feeds itself
    assign fast_or       = |fast_status[DATA_W-1:1];

    // normal enable mask: set by its own write, cleared by clear or fast set
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            normal_en <= RESET_VALUE;
        end else if (wr_strobe && WB_ADR_I == OFS_NORMAL_EN) begin
            normal_en <= (normal_en | wdata) & SRC_VALID & ~32'h0000_0001;
        end else if (wr_strobe && WB_ADR_I == OFS_NORMAL_CLR) begin
            normal_en <= normal_en & ~wdata;
        end else if (wr_strobe && WB_ADR_I == OFS_FAST_EN) begin
            normal_en <= normal_en & ~wdata;
        end
    end

    // fast enable mask, mirror image of the normal one
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            fast_en <= RESET_VALUE;
        end else if (wr_strobe && WB_ADR_I == OFS_FAST_EN) begin
            fast_en <= (fast_en | wdata) & SRC_VALID & ~32'h0000_0001;
        end else if (wr_strobe && WB_ADR_I == OFS_FAST_CLR) begin
            fast_en <= fast_en & ~wdata;
        end else if (wr_strobe && WB_ADR_I == OFS_NORMAL_EN) begin
            fast_en <= fast_en & ~wdata;
        end
    end

    // software source and nesting configuration, plain read/write
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            soft_cfg <= RESET_VALUE;
            ctrl_cfg <= RESET_VALUE;
        end else if (wr_strobe && WB_ADR_I == OFS_SOFT_CFG) begin
            soft_cfg <= (soft_cfg & ~lane_mask(WB_SEL_I)) | (wdata & SOFT_CFG_VALID);
        end else if (wr_strobe && WB_ADR_I == OFS_CTRL_CFG) begin
            ctrl_cfg <= (ctrl_cfg & ~lane_mask(WB_SEL_I)) | (wdata & CTRL_CFG_VALID);
        end
    end

    // request lines to the core, registered so outputs come from flops
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            IRQ_OUT <= 1'b0;
            FIQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |shape(normal_status, fast_or);
            FIQ_OUT <= fast_or;
        end
    end

    // edge history of the core lines feeds the event status
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_prev <= 1'b0;
            fiq_prev <= 1'b0;
        end else begin
            irq_prev <= IRQ_OUT;
            fiq_prev <= FIQ_OUT;
        end
    end

    // address check for the defined map
    always_comb begin
        unique case (WB_ADR_I)
            OFS_NORMAL_STATUS, OFS_NORMAL_RAW, OFS_NORMAL_EN, OFS_NORMAL_CLR,
            OFS_FAST_STATUS, OFS_FAST_RAW, OFS_FAST_EN, OFS_FAST_CLR,
            OFS_SOFT_CFG, OFS_CTRL_CFG, OFS_EVENT_STATUS, OFS_EVENT_MASK:
                addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    end

    // sticky events; a new event in a clearing read cycle wins over the clear
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ev_status <= EV_RESET;
        end else begin
            ev_status <= ((rd_strobe && WB_ADR_I == OFS_EVENT_STATUS) ? EV_RESET : ev_status)
                       | {bus_req & ~addr_known, FIQ_OUT & ~fiq_prev, IRQ_OUT & ~irq_prev};
        end
    end

    // event mask, plain read/write
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ev_mask <= EV_RESET;
        end else if (wr_strobe && WB_ADR_I == OFS_EVENT_MASK) begin
            ev_mask <= wdata[EV_W-1:0];
        end
    end

    // level interrupt while an unmasked event is pending
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            INT_OUT <= 1'b0;
        end else begin
            INT_OUT <= |(ev_status & ev_mask);
        end
    end

    // read mux; write-only and unmapped addresses read zero
    always_comb begin
        next_rdata = RESET_VALUE;
        unique case (WB_ADR_I)
            OFS_NORMAL_STATUS: next_rdata = shape(normal_status, fast_or);
            OFS_NORMAL_RAW:    next_rdata = shape(normal_raw, fast_or);
            OFS_NORMAL_EN:     next_rdata = shape(normal_en, fast_or);
            OFS_FAST_STATUS:   next_rdata = shape(fast_status, fast_or);
            OFS_FAST_RAW:      next_rdata = shape(fast_raw, fast_or);
            OFS_FAST_EN:       next_rdata = shape(fast_en, fast_or);
            OFS_SOFT_CFG:      next_rdata = soft_cfg;
            OFS_CTRL_CFG:      next_rdata = ctrl_cfg;
            OFS_EVENT_STATUS:  next_rdata = {29'h0000_0000, ev_status};
            OFS_EVENT_MASK:    next_rdata = {29'h0000_0000, ev_mask};
            default:           next_rdata = RESET_VALUE;
        endcase
    end

    // acknowledge one cycle after the request; unmapped addresses also ack
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= RESET_VALUE;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= rd_strobe ? next_rdata : RESET_VALUE;
        end
    end

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_write_to(logic [DATA_W-1:0] adr);
        wr_strobe && WB_ADR_I == adr;
    endsequence

    sequence s_read_of(logic [DATA_W-1:0] adr);
        rd_strobe && WB_ADR_I == adr;
    endsequence

    a_irq_line_or: assert property (
        (|normal_status || fast_or) |=> IRQ_OUT)
        else $error("normal line low while a status bit is set");

    a_fiq_line_or: assert property (
        ##1 FIQ_OUT == $past(|fast_status[DATA_W-1:1]))
        else $error("fast line does not follow fast status OR");

    a_status_and: assert property (
        s_read_of(OFS_NORMAL_STATUS) |=>
            WB_ACK_O && WB_DAT_O[31:1] == $past(normal_raw[31:1] & normal_en[31:1]))
        else $error("normal status read differs from raw AND enable");

    a_fast_status_and: assert property (
        s_read_of(OFS_FAST_STATUS) |=>
            WB_DAT_O[31:1] == $past(fast_raw[31:1] & fast_en[31:1]))
        else $error("fast status read differs from raw AND enable");

    a_enable_sets: assert property (
        s_write_to(OFS_NORMAL_EN) |=>
            normal_en == (($past(normal_en) | $past(wdata)) & SRC_VALID & 32'hFFFF_FFFE))
        else $error("normal enable write did not set or keep bits");

    a_fast_enable_sets: assert property (
        s_write_to(OFS_FAST_EN) |=> (fast_en & $past(wdata) & SRC_VALID & 32'hFFFF_FFFE)
            == ($past(wdata) & SRC_VALID & 32'hFFFF_FFFE))
        else $error("fast enable write did not set bits");

    a_clear_mask: assert property (
        s_write_to(OFS_NORMAL_CLR) |=>
            normal_en == ($past(normal_en) & ~$past(wdata)))
        else $error("normal clear affected the wrong bits");

    a_fast_clear_mask: assert property (
        s_write_to(OFS_FAST_CLR) |=> fast_en == ($past(fast_en) & ~$past(wdata)))
        else $error("fast clear affected the wrong bits");

    a_levels_exclusive: assert property (
        (normal_en & fast_en) == 32'h0000_0000)
        else $error("a source is enabled at both levels");

    a_reserved_zero: assert property (
        s_read_of(OFS_NORMAL_RAW) |=> (WB_DAT_O & ~SRC_VALID & 32'hFFFF_FFFE) == 32'h0)
        else $error("reserved raw bits read nonzero");

    a_soft_source: assert property (
        s_read_of(OFS_NORMAL_RAW) |=>
            WB_DAT_O[BIT_SOFT] == $past(soft_cfg[SOFT_NORMAL_BIT]))
        else $error("software source not reflected in raw bit 1");

    a_bit0_fast_or: assert property (
        rd_strobe && WB_ADR_I == OFS_NORMAL_EN |=> WB_DAT_O[0] == $past(fast_or))
        else $error("bit 0 does not show the fast OR");

    a_raw_follows: assert property (
        normal_raw[BIT_TIMER0] == $past(PERIPH_REQ[BIT_TIMER0], 2))
        else $error("raw bit does not follow its request line");

    a_ack_one_cycle: assert property (
        bus_req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus answer not a single cycle one edge after request");

    // the OR is two-sided: the normal line must also fall when nothing is pending
    a_irq_line_idle: assert property (
        (!(|normal_status) && !fast_or) |=> !IRQ_OUT)
        else $error("normal line high with no status bit set");

    a_fast_raw_follows: assert property (
        fast_raw[BIT_UART] == $past(PERIPH_REQ[BIT_UART], 2))
        else $error("fast raw bit does not follow its request line");

    a_fast_soft_source: assert property (
        s_read_of(OFS_FAST_RAW) |=>
            WB_DAT_O[BIT_SOFT] == $past(soft_cfg[SOFT_FAST_BIT]))
        else $error("software source not reflected in fast raw bit 1");

    a_clear_reads_zero: assert property (
        rd_strobe && (WB_ADR_I == OFS_NORMAL_CLR || WB_ADR_I == OFS_FAST_CLR) |=>
            WB_DAT_O == RESET_VALUE)
        else $error("write-only clear register read nonzero");

    // a stray write to the normal raw or normal status register must not touch either mask
    a_raw_writes_ignored: assert property (
        wr_strobe && (WB_ADR_I == OFS_NORMAL_RAW || WB_ADR_I == OFS_NORMAL_STATUS) |=>
            normal_en == $past(normal_en) && fast_en == $past(fast_en))
        else $error("write to a read-only level register changed a mask");

    a_unused_masked: assert property (
        ((normal_en | fast_en) & ~SRC_VALID) == RESET_VALUE)
        else $error("reserved or unused slot enabled");

    a_nest_bits_only: assert property (
        (ctrl_cfg & ~CTRL_CFG_VALID) == RESET_VALUE)
        else $error("controller configuration holds undefined bits");

    a_data_idle_zero: assert property (
        !WB_ACK_O |-> WB_DAT_O == RESET_VALUE)
        else $error("read data not zero outside the answer cycle");

    // event line is a registered level of the unmasked sticky bits
    a_int_level: assert property (
        ##1 INT_OUT == $past(|(ev_status & ev_mask)))
        else $error("event line does not follow unmasked event status");

endmodule // dim_top

/* test/dim_periph_model.sv */
// dim_periph_model: stand-in for the peripheral request lines of dim_top.
// assumes requests are levels held until the bench withdraws them.
`timescale 1ns/1ps
module dim_periph_model
    import dim_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] want,
    output logic      [31:0] periph_req = 32'h0000_0000
);
    // lines move just after an edge, like peripheral flops; slots with no
    // peripheral behind them (soft, reserved, unused) are never driven high
    always_ff @(posedge ref_clk) begin
        periph_req <= want & PERIPH_VALID;
    end
endmodule // dim_periph_model

/* test/test_dual_level_interrupt_mask_unit.sv */
// test_dual_level_interrupt_mask_unit: register-level bench for dim_top.
// assumes dim_pkg is compiled first; one 100 MHz clock, sync reset.
`timescale 1ns/1ps
module test_dual_level_interrupt_mask_unit;
    import dim_pkg::*;
    logic        ref_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [31:0] adr        = 32'h0;
    logic [31:0] wdat       = 32'h0;
    logic [3:0]  sel        = 4'h0;
    logic [3:0]  lanes      = 4'hF;
    logic [31:0] lines_want = 32'h0;
    logic [31:0] periph_req;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic        fiq;
    logic        intr;
    int          n_fail     = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    logic [31:0] lvl_regs [8] = '{OFS_NORMAL_STATUS, OFS_NORMAL_RAW, OFS_NORMAL_EN,
        OFS_NORMAL_CLR, OFS_FAST_STATUS, OFS_FAST_RAW, OFS_FAST_EN, OFS_FAST_CLR};

    always #5 ref_clk = ~ref_clk;

    dim_top dut_u (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PERIPH_REQ(periph_req),
        .IRQ_OUT(irq), .FIQ_OUT(fiq), .INT_OUT(intr));

    dim_periph_model periph_u (.ref_clk(ref_clk), .want(lines_want),
        .periph_req(periph_req));

    // hang guard: the sequence needs a few hundred cycles at most
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // classic single cycle; no latency assumed, only the hang guard cuts a wait
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= lanes;
        wdat <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(what, rdat, exp);
    endtask

    // outputs are levels behind sync flops, so allow a short settle window
    task automatic wait_out(input string what, input int which, input logic exp);
        logic v;
        v = (which == 0) ? irq : (which == 1) ? fiq : intr;
        for (int n = 0; n < 10 && v !== exp; n++) begin
            @(posedge ref_clk);
            v = (which == 0) ? irq : (which == 1) ? fiq : intr;
        end
        check(what, {31'h0, v}, {31'h0, exp});
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // every level register starts cleared, request lines low
        for (int i = 0; i < 8; i++) begin
            rd("level_reg_reset", lvl_regs[i], 32'h0);
        end
        check("req_lines_reset", {29'h0, irq, fiq, intr}, 32'h0);
        $display("test reset_values done");

        // enable is set-only; bit 0 and reserved slots never stick
        wb(1'b1, OFS_NORMAL_EN, 32'h8000_0385);
        rd("normal_en_set", OFS_NORMAL_EN, 32'h0000_0104);
        wb(1'b1, OFS_NORMAL_EN, 32'h0);
        rd("normal_en_keep", OFS_NORMAL_EN, 32'h0000_0104);
        wb(1'b1, OFS_NORMAL_RAW, 32'hFFFF_FFFF);
        wb(1'b1, OFS_NORMAL_STATUS, 32'hFFFF_FFFF);
        rd("normal_raw_ro", OFS_NORMAL_RAW, 32'h0);
        rd("normal_sta_ro", OFS_NORMAL_STATUS, 32'h0);
        $display("test enable_set_only done");

        // timer0 enabled, uart not: only timer0 reaches status
        lines_want <= 32'h0000_2004;
        wait_out("irq_rise", 0, 1'b1);
        rd("normal_raw", OFS_NORMAL_RAW, 32'h0000_2004);
        rd("fast_raw", OFS_FAST_RAW, 32'h0000_2004);
        rd("normal_sta", OFS_NORMAL_STATUS, 32'h0000_0004);
        check("fiq_idle", {31'h0, fiq}, 32'h0);
        $display("test raw_and_status done");

        // enabling at one level strips the other; fast OR shows in bit 0
        wb(1'b1, OFS_FAST_EN, 32'h0000_2004);
        wait_out("fiq_rise", 1, 1'b1);
        rd("fast_en", OFS_FAST_EN, 32'h0000_2005);
        rd("normal_en_swap", OFS_NORMAL_EN, 32'h0000_0101);
        rd("fast_sta", OFS_FAST_STATUS, 32'h0000_2005);
        rd("normal_sta_or", OFS_NORMAL_STATUS, 32'h0000_0001);
        check("irq_from_fast", {31'h0, irq}, 32'h1);
        wb(1'b1, OFS_NORMAL_EN, 32'h0000_2000);
        rd("fast_en_swap", OFS_FAST_EN, 32'h0000_0005);
        rd("normal_sta_2", OFS_NORMAL_STATUS, 32'h0000_2001);
        $display("test level_exclusion done");

        // clear registers drop only the bits written as one
        wb(1'b1, OFS_FAST_CLR, 32'h0000_0004);
        wait_out("fiq_fall", 1, 1'b0);
        rd("fast_en_clr", OFS_FAST_EN, 32'h0);
        rd("fast_clr_wo", OFS_FAST_CLR, 32'h0);
        wb(1'b1, OFS_NORMAL_CLR, 32'h0000_2000);
        rd("normal_en_clr", OFS_NORMAL_EN, 32'h0000_0100);
        rd("normal_clr_wo", OFS_NORMAL_CLR, 32'h0);
        wait_out("irq_fall", 0, 1'b0);
        lines_want <= 32'h0;
        $display("test mask_clear done");

        // software source goes straight into raw bit 1 of either level
        wb(1'b1, OFS_SOFT_CFG, 32'h0000_0002);
        rd("soft_normal_raw", OFS_NORMAL_RAW, 32'h0000_0002);
        wb(1'b1, OFS_NORMAL_EN, 32'h0000_0002);
        wait_out("irq_soft", 0, 1'b1);
        wb(1'b1, OFS_SOFT_CFG, 32'h0000_0004);
        rd("soft_normal_off", OFS_NORMAL_RAW, 32'h0);
        wb(1'b1, OFS_FAST_EN, 32'h0000_0002);
        rd("soft_fast_sta", OFS_FAST_STATUS, 32'h0000_0003);
        rd("soft_normal_en", OFS_NORMAL_EN, 32'h0000_0101);
        wb(1'b1, OFS_SOFT_CFG, 32'h0);
        wait_out("fiq_soft_off", 1, 1'b0);
        rd("ctrl_cfg_reset", OFS_CTRL_CFG, 32'h0);
        wb(1'b1, OFS_CTRL_CFG, 32'hFFFF_FFFF);
        rd("ctrl_cfg_rw", OFS_CTRL_CFG, 32'h0000_0003);
        // only the second byte lane is written, so timer0 stays off
        lanes = 4'h2;
        wb(1'b1, OFS_NORMAL_EN, 32'h0000_2004);
        lanes = 4'hF;
        rd("normal_en_lanes", OFS_NORMAL_EN, 32'h0000_2100);
        $display("test soft_source done");

        // events stay sticky under mask, clear on read
        wb(1'b1, OFS_EVENT_MASK, 32'h0);
        rd("unmapped_read", 32'hFFFF_0300, 32'h0);
        wait_out("int_masked", 2, 1'b0);
        wb(1'b1, OFS_EVENT_MASK, 32'h0000_0004);
        wait_out("int_rise", 2, 1'b1);
        rd("event_sta", OFS_EVENT_STATUS, 32'h0000_0007);
        wait_out("int_fall", 2, 1'b0);
        rd("event_sta_cleared", OFS_EVENT_STATUS, 32'h0);
        $display("test events done");
        close_out();
    end
endmodule // test_dual_level_interrupt_mask_unit
